// *** logic/rqc_pkg.sv ***
// Operation
// (RULE1) Two network ports, one host port classified
// (RULE2) Matching IO connection tag diverts to real-time path
// (RULE3) Green and red IO use own descriptors, triple buffers
// (RULE4) Shadow connection list swapped at cycle boundary
// (RULE5) Separate interrupts: buffer, list swap, hold timeout
// (RULE6) Clock sync frames consumed, never queued to host
// (RULE7) Relayed sync time gains line and bridge delay
// (RULE8) Discovery frame on neighbour change, else periodic
// (RULE9) Discovery and redundancy frames to highest queue
// (RULE10) Ring break flushes table, floods both ports
// (RULE11) Hold timeout survives two missing cyclic frames
// (RULE12) Config protocol and alarm frames to second queue
// (RULE13) Identify requests pass only on station name match
// (RULE14) VLAN priority 4 to 7 third queue, else lowest
// (RULE15) Broadcasts into lowest queue capped per window
// (RULE16) Received frame interrupts paced over several frames
// (RULE17) Exactly four host queues, top two for management
// (RULE18) Industrial frames recognised by type 0x8892
// (RULE19) Discovery frames recognised by type 0x88CC
// (RULE20) Fixed precedence, first matching class decides
package rqc_pkg;
  localparam int CLK_HZ         = 50_000_000;
  localparam int TICK_US        = 1000;
  localparam int TICK_CYC       = CLK_HZ / 1_000_000 * TICK_US;
  localparam int LLDP_PERIOD_MS = 2000;
  localparam int BCAST_WIN_MS   = 10;
  localparam int PACE_MS        = 1;

  localparam logic [15:0] ETYPE_RT   = 16'h8892;
  localparam logic [15:0] ETYPE_LLDP = 16'h88cc;
  localparam logic [2:0]  PCP_HI_MIN = 3'h4;
  localparam logic [3:0]  DHT_LIMIT  = 4'h3;

  localparam logic [1:0] Q_MGMT = 2'h3;
  localparam logic [1:0] Q_DCP  = 2'h2;
  localparam logic [1:0] Q_PRIO = 2'h1;
  localparam logic [1:0] Q_BEST = 2'h0;

  localparam logic [1:0] PORT_A    = 2'h0;
  localparam logic [1:0] PORT_B    = 2'h1;
  localparam logic [1:0] PORT_HOST = 2'h2;

  localparam logic [1:0] BUF_IDX_RST = 2'h0;
  localparam logic [1:0] BUF_IDX_MAX = 2'h2;

  typedef enum logic [2:0] {
    SUB_IO    = 3'b000,
    SUB_SYNC  = 3'b001,
    SUB_DELAY = 3'b010,
    SUB_DCP   = 3'b011,
    SUB_IDENT = 3'b100,
    SUB_ALARM = 3'b101,
    SUB_MRP   = 3'b110,
    SUB_OTHER = 3'b111
  } rqc_sub_t;

  typedef enum logic [2:0] {
    DST_RT   = 3'b000,
    DST_SYNC = 3'b001,
    DST_Q3   = 3'b010,
    DST_Q2   = 3'b011,
    DST_Q1   = 3'b100,
    DST_Q0   = 3'b101,
    DST_DROP = 3'b110
  } rqc_dest_t;
endpackage

// *** logic/rqc_skid_buf.sv ***
`timescale 1ns/1ps
module rqc_skid_buf #(
  parameter int W = 12
) (
  input  wire logic         i_clk,
  input  wire logic         i_rst,
  input  wire logic         i_valid,
  output logic              o_ready,
  input  wire logic [W-1:0] i_data,
  output logic              o_valid,
  input  wire logic         i_ready,
  output logic [W-1:0]      o_data
);
  logic [1:0]   count;
  logic [W-1:0] slot1;
  logic [1:0]   next_count;
  wire          push = i_valid & o_ready;
  wire          pop  = o_valid & i_ready;

  assign next_count = count + {1'b0, push} - {1'b0, pop};

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      count   <= 2'h0;
      o_ready <= 1'b0;
      o_valid <= 1'b0;
    end else begin
      count   <= next_count;
      o_ready <= (next_count != 2'h2);
      o_valid <= (next_count != 2'h0);
    end
  end

  // Head slot drives the output directly so data stays registered
  always_ff @(posedge i_clk) begin
    if (pop && (count == 2'h2 || push && count == 2'h1)) begin
      o_data <= (count == 2'h2) ? slot1 : i_data;
    end else if (push && count == 2'h0) begin
      o_data <= i_data;
    end
    if (push && (count == 2'h2 || count == 2'h1 && !pop)) begin
      slot1 <= i_data;
    end
  end
endmodule

// *** logic/rqc_classifier.sv ***
`timescale 1ns/1ps
module rqc_classifier #(
  parameter int N_CONN     = 8,
  parameter int NAME_BYTES = 16,
  parameter int TW         = 32,
  parameter int TICK_CYC   = rqc_pkg::TICK_CYC,
  parameter int CW         = $clog2(N_CONN)
) (
  input  wire logic                    I_SYS_CLK,
  input  wire logic                    I_RST,
  input  wire logic                    I_FRM_VALID,
  output logic                         O_FRM_READY,
  input  wire logic [1:0]              I_FRM_PORT,
  input  wire logic [15:0]             I_FRM_ETYPE,
  input  wire logic [2:0]              I_FRM_SUB,
  input  wire logic [15:0]             I_FRM_TAG,
  input  wire logic                    I_FRM_VLAN,
  input  wire logic [2:0]              I_FRM_PCP,
  input  wire logic                    I_FRM_BCAST,
  input  wire logic [7:0]              I_FRM_ID,
  input  wire logic [7:0]              I_FRM_NAME_LEN,
  input  wire logic [8*NAME_BYTES-1:0] I_FRM_NAME,
  input  wire logic [TW-1:0]           I_FRM_TIME,
  input  wire logic [7:0]              I_LOCAL_NAME_LEN,
  input  wire logic [8*NAME_BYTES-1:0] I_LOCAL_NAME,
  input  wire logic [TW-1:0]           I_LINE_DELAY,
  input  wire logic [TW-1:0]           I_BRIDGE_DELAY,
  input  wire logic                    I_CYCLE_START,
  input  wire logic                    I_SHD_WE,
  input  wire logic [CW-1:0]           I_SHD_IDX,
  input  wire logic [15:0]             I_SHD_TAG,
  input  wire logic                    I_SHD_EN,
  input  wire logic                    I_SHD_RED,
  input  wire logic                    I_SHD_COMMIT,
  input  wire logic [1:0]              I_NBR_CHANGE,
  input  wire logic                    I_RING_BREAK,
  input  wire logic                    I_RING_RESTORED,
  input  wire logic [7:0]              I_BCAST_LIMIT,
  input  wire logic [7:0]              I_PACE_COUNT,
  input  wire logic                    I_RX_IRQ_ACK,
  input  wire logic                    I_Q_READY,
  output logic                         O_Q_VALID,
  output logic [1:0]                   O_Q_NUM,
  output logic [1:0]                   O_Q_PORT,
  output logic [7:0]                   O_Q_ID,
  output logic                         O_RT_VALID,
  output logic                         O_RT_RED,
  output logic [CW-1:0]                O_RT_CONN,
  output logic [1:0]                   O_RT_BUF,
  output logic                         O_SYNC_VALID,
  output logic                         O_SYNC_MEAS,
  output logic [1:0]                   O_SYNC_PORT,
  output logic [TW-1:0]                O_SYNC_FWD_TIME,
  output logic                         O_LLDP_TX,
  output logic [1:0]                   O_LLDP_PORT,
  output logic                         O_FDB_FLUSH,
  output logic                         O_FLOOD_BOTH,
  output logic                         O_FILTER_DROP,
  output logic                         O_IRQ_BUF,
  output logic                         O_IRQ_LIST,
  output logic                         O_IRQ_DHT,
  output logic [N_CONN-1:0]            O_DHT_EXPIRED,
  output logic                         O_LIST_PENDING,
  output logic                         O_IRQ_RX
);
  localparam int TCW = $clog2(TICK_CYC);

  function automatic logic name_eq(input logic [8*NAME_BYTES-1:0] a, input logic [8*NAME_BYTES-1:0] b,
                                   input logic [7:0] len);
    logic eq;
    eq = 1'b1;
    for (int i = 0; i < NAME_BYTES; i++) begin
      if (i < len && a[8*i +: 8] != b[8*i +: 8]) begin
        eq = 1'b0;
      end
    end
    return eq;
  endfunction

  function automatic logic [1:0] other_port(input logic [1:0] p);
    return (p == rqc_pkg::PORT_A) ? rqc_pkg::PORT_B : rqc_pkg::PORT_A;
  endfunction

  // Connection lists, active and shadow
  logic [15:0]       act_tag [N_CONN];
  logic [N_CONN-1:0] act_en;
  logic [N_CONN-1:0] act_red;
  logic [15:0]       shd_tag [N_CONN];
  logic [N_CONN-1:0] shd_en;
  logic [N_CONN-1:0] shd_red;
  logic [1:0]        wr_idx  [N_CONN];
  logic [3:0]        miss    [N_CONN];

  // Millisecond tick and slow timers
  logic [TCW-1:0] tick_cnt;
  logic           ms_tick;
  logic [15:0]    lldp_ms;
  logic [15:0]    bwin_ms;
  logic [15:0]    pace_ms;
  logic [7:0]     bcnt;
  logic [7:0]     pend;

  // Connection match across the active list
  logic          hit;
  logic [CW-1:0] hit_idx;
  always_comb begin
    hit     = 1'b0;
    hit_idx = '0;
    for (int i = N_CONN - 1; i >= 0; i--) begin
      if (act_en[i] && act_tag[i] == I_FRM_TAG) begin
        hit     = 1'b1;
        hit_idx = CW'(i);
      end
    end
  end

  wire       take      = I_FRM_VALID & O_FRM_READY;
  wire       is_rt     = (I_FRM_ETYPE == rqc_pkg::ETYPE_RT); // RULE18
  wire       is_lldp   = (I_FRM_ETYPE == rqc_pkg::ETYPE_LLDP); // RULE19
  wire [2:0] sub       = I_FRM_SUB;
  wire       c_conn    = is_rt && sub == rqc_pkg::SUB_IO && hit; // RULE2
  wire       c_sync    = is_rt && (sub == rqc_pkg::SUB_SYNC || sub == rqc_pkg::SUB_DELAY); // RULE6
  wire       c_mgmt    = is_lldp || (is_rt && sub == rqc_pkg::SUB_MRP); // RULE9
  wire       c_dcp     = is_rt && (sub == rqc_pkg::SUB_DCP || sub == rqc_pkg::SUB_ALARM
                                   || sub == rqc_pkg::SUB_IDENT); // RULE12
  wire       name_ok   = (I_FRM_NAME_LEN == I_LOCAL_NAME_LEN)
                         && name_eq(I_FRM_NAME, I_LOCAL_NAME, I_LOCAL_NAME_LEN); // RULE13
  wire       ident_bad = sub == rqc_pkg::SUB_IDENT && !name_ok; // RULE13
  wire       c_prio    = !is_rt && I_FRM_VLAN && I_FRM_PCP >= rqc_pkg::PCP_HI_MIN; // RULE14
  wire       bcast_cap = I_FRM_BCAST && I_BCAST_LIMIT != 8'h00 && bcnt >= I_BCAST_LIMIT; // RULE15

  function automatic logic [1:0] q_num(input rqc_pkg::rqc_dest_t d);
    case (d)
      rqc_pkg::DST_Q3: return rqc_pkg::Q_MGMT;
      rqc_pkg::DST_Q2: return rqc_pkg::Q_DCP;
      rqc_pkg::DST_Q1: return rqc_pkg::Q_PRIO;
      default:         return rqc_pkg::Q_BEST;
    endcase
  endfunction

  function automatic logic [1:0] next_buf(input logic [1:0] b);
    return (b == rqc_pkg::BUF_IDX_MAX) ? rqc_pkg::BUF_IDX_RST : b + 2'h1;
  endfunction

  function automatic logic ms_end(input logic [15:0] c, input int lim);
    return c == 16'(lim - 1);
  endfunction

  function automatic logic [15:0] ms_step(input logic [15:0] c, input int lim);
    return ms_end(c, lim) ? 16'h0 : c + 16'h1;
  endfunction

  // First matching class wins
  rqc_pkg::rqc_dest_t dest;
  assign dest = c_conn    ? rqc_pkg::DST_RT // RULE20
              : c_sync    ? rqc_pkg::DST_SYNC
              : c_mgmt    ? rqc_pkg::DST_Q3
              : c_dcp     ? (ident_bad ? rqc_pkg::DST_DROP : rqc_pkg::DST_Q2)
              : c_prio    ? rqc_pkg::DST_Q1
              : bcast_cap ? rqc_pkg::DST_DROP
              : rqc_pkg::DST_Q0;

  wire        is_queue = dest == rqc_pkg::DST_Q3 || dest == rqc_pkg::DST_Q2
                         || dest == rqc_pkg::DST_Q1 || dest == rqc_pkg::DST_Q0; // RULE17
  wire        to_queue = take && is_queue;
  wire        to_rt    = take && dest == rqc_pkg::DST_RT; // RULE2
  wire        to_sync  = take && dest == rqc_pkg::DST_SYNC; // RULE6
  wire        to_drop  = take && dest == rqc_pkg::DST_DROP;
  wire        bc_take  = to_queue && dest == rqc_pkg::DST_Q0 && I_FRM_BCAST; // RULE15
  wire [11:0] q_word   = {q_num(dest), I_FRM_PORT, I_FRM_ID}; // RULE1
  wire [11:0] q_out;

  // Two entries absorb a host stall without dropping a classified frame
  rqc_skid_buf #(
    .W (12)
  ) rqc_skid_buf_i (
    .i_clk   (I_SYS_CLK),
    .i_rst   (I_RST),
    .i_valid (to_queue),
    .o_ready (O_FRM_READY),
    .i_data  (q_word),
    .o_valid (O_Q_VALID),
    .i_ready (I_Q_READY),
    .o_data  (q_out)
  );
  assign O_Q_NUM  = q_out[11:10];
  assign O_Q_PORT = q_out[9:8];
  assign O_Q_ID   = q_out[7:0];

  // Millisecond tick shared by all slow timers
  wire tick_end = tick_cnt == TCW'(TICK_CYC - 1);
  always_ff @(posedge I_SYS_CLK) begin
    if (I_RST || tick_end) begin
      tick_cnt <= '0;
    end else begin
      tick_cnt <= tick_cnt + 1'b1;
    end
    ms_tick <= !I_RST && tick_end;
  end

  wire lldp_period = ms_tick && ms_end(lldp_ms, rqc_pkg::LLDP_PERIOD_MS); // RULE8
  wire bwin_end    = ms_tick && ms_end(bwin_ms, rqc_pkg::BCAST_WIN_MS); // RULE15
  wire pace_end    = ms_tick && ms_end(pace_ms, rqc_pkg::PACE_MS); // RULE16

  always_ff @(posedge I_SYS_CLK) begin
    if (I_RST) begin
      lldp_ms <= 16'h0;
      bwin_ms <= 16'h0;
      pace_ms <= 16'h0;
    end else if (ms_tick) begin
      lldp_ms <= ms_step(lldp_ms, rqc_pkg::LLDP_PERIOD_MS);
      bwin_ms <= ms_step(bwin_ms, rqc_pkg::BCAST_WIN_MS);
      pace_ms <= ms_step(pace_ms, rqc_pkg::PACE_MS);
    end
  end

  // Window restart still counts a broadcast taken in the same cycle
  always_ff @(posedge I_SYS_CLK) begin
    if (I_RST) begin
      bcnt <= 8'h00;
    end else if (bwin_end) begin
      bcnt <= {7'h00, bc_take};
    end else if (bc_take && bcnt != 8'hff) begin
      bcnt <= bcnt + 8'h01; // RULE15
    end
  end

  // Shadow list, swapped in only at a cycle start
  wire swap = I_CYCLE_START && O_LIST_PENDING; // RULE4
  always_ff @(posedge I_SYS_CLK) begin
    if (I_RST) begin
      shd_en  <= '0;
      shd_red <= '0;
    end else if (I_SHD_WE) begin
      shd_tag[I_SHD_IDX] <= I_SHD_TAG;
      shd_en[I_SHD_IDX]  <= I_SHD_EN;
      shd_red[I_SHD_IDX] <= I_SHD_RED;
    end
  end

  always_ff @(posedge I_SYS_CLK) begin
    if (I_RST) begin
      O_LIST_PENDING <= 1'b0;
    end else if (I_SHD_COMMIT) begin
      O_LIST_PENDING <= 1'b1;
    end else if (swap) begin
      O_LIST_PENDING <= 1'b0;
    end
    O_IRQ_LIST <= !I_RST && swap; // RULE5
  end

  always_ff @(posedge I_SYS_CLK) begin
    if (I_RST) begin
      act_en  <= '0;
      act_red <= '0;
    end else if (swap) begin
      act_en  <= shd_en;
      act_red <= shd_red;
      act_tag <= shd_tag; // RULE4
    end
  end

  // Hold timeout: third missing cycle in a row expires the connection
  logic [N_CONN-1:0] seen;
  logic [N_CONN-1:0] dht_hit;
  always_comb begin
    dht_hit = '0;
    for (int i = 0; i < N_CONN; i++) begin
      dht_hit[i] = I_CYCLE_START && !swap && act_en[i] && !seen[i]
                   && miss[i] == rqc_pkg::DHT_LIMIT - 4'h1
                   && !(to_rt && hit_idx == CW'(i)); // RULE11
    end
  end

  always_ff @(posedge I_SYS_CLK) begin
    for (int i = 0; i < N_CONN; i++) begin
      if (I_RST || swap) begin
        wr_idx[i]        <= rqc_pkg::BUF_IDX_RST;
        miss[i]          <= 4'h0;
        seen[i]          <= 1'b0;
        O_DHT_EXPIRED[i] <= 1'b0;
      end else if (to_rt && hit_idx == CW'(i)) begin
        wr_idx[i]        <= next_buf(wr_idx[i]); // RULE3
        miss[i]          <= 4'h0;
        seen[i]          <= 1'b1;
        O_DHT_EXPIRED[i] <= 1'b0;
      end else if (I_CYCLE_START && act_en[i]) begin
        seen[i]          <= 1'b0;
        miss[i]          <= seen[i] ? 4'h0
                            : (miss[i] == rqc_pkg::DHT_LIMIT) ? miss[i] : miss[i] + 4'h1; // RULE11
        O_DHT_EXPIRED[i] <= O_DHT_EXPIRED[i] | dht_hit[i];
      end
    end
    O_IRQ_DHT <= !I_RST && (dht_hit != '0); // RULE5
  end

  // Real-time path skips the queues but still stalls when O_FRM_READY is low
  always_ff @(posedge I_SYS_CLK) begin
    O_RT_VALID <= !I_RST && to_rt; // RULE2
    O_IRQ_BUF  <= !I_RST && to_rt; // RULE5
    if (to_rt) begin
      O_RT_CONN <= hit_idx;
      O_RT_RED  <= act_red[hit_idx]; // RULE3
      O_RT_BUF  <= next_buf(wr_idx[hit_idx]); // RULE3
    end
  end

  // Sync frames end here and never reach a host queue
  always_ff @(posedge I_SYS_CLK) begin
    O_SYNC_VALID  <= !I_RST && to_sync; // RULE6
    O_FILTER_DROP <= !I_RST && to_drop; // RULE13
    if (to_sync) begin
      O_SYNC_MEAS     <= sub == rqc_pkg::SUB_DELAY;
      O_SYNC_PORT     <= other_port(I_FRM_PORT);
      O_SYNC_FWD_TIME <= I_FRM_TIME + I_LINE_DELAY + I_BRIDGE_DELAY; // RULE7
    end
  end

  // Owed discovery frames, one bit per outgoing port
  logic [1:0] lldp_owed;
  wire  [1:0] lldp_set    = {I_NBR_CHANGE[0], I_NBR_CHANGE[1]} | {2{lldp_period}}; // RULE8
  wire  [1:0] lldp_served = lldp_owed[0] ? 2'b01 : {lldp_owed[1], 1'b0};
  always_ff @(posedge I_SYS_CLK) begin
    if (I_RST) begin
      lldp_owed <= 2'b00;
      O_LLDP_TX <= 1'b0;
    end else begin
      lldp_owed   <= (lldp_owed & ~lldp_served) | lldp_set; // RULE8
      O_LLDP_TX   <= lldp_owed != 2'b00;
      O_LLDP_PORT <= lldp_owed[0] ? rqc_pkg::PORT_A : rqc_pkg::PORT_B;
    end
  end

  // Ring break: one flush pulse, flooding until restored
  logic ring_q;
  wire  ring_rise = I_RING_BREAK && !ring_q;
  always_ff @(posedge I_SYS_CLK) begin
    ring_q      <= !I_RST && I_RING_BREAK;
    O_FDB_FLUSH <= !I_RST && ring_rise; // RULE10
    if (I_RST) begin
      O_FLOOD_BOTH <= 1'b0;
    end else if (ring_rise) begin
      O_FLOOD_BOTH <= 1'b1; // RULE10
    end else if (I_RING_RESTORED) begin
      O_FLOOD_BOTH <= 1'b0;
    end
  end

  // Pacing trades latency for fewer host interrupts
  wire [7:0] pend_base = I_RX_IRQ_ACK ? 8'h00 : pend;
  wire [7:0] next_pend = (to_queue && pend_base != 8'hff) ? pend_base + 8'h01 : pend_base;
  wire       irq_set   = (I_PACE_COUNT != 8'h00 && next_pend >= I_PACE_COUNT)
                         || (pace_end && next_pend != 8'h00); // RULE16
  always_ff @(posedge I_SYS_CLK) begin
    if (I_RST) begin
      pend     <= 8'h00;
      O_IRQ_RX <= 1'b0;
    end else begin
      pend     <= next_pend;
      O_IRQ_RX <= irq_set || (O_IRQ_RX && !I_RX_IRQ_ACK); // RULE16
    end
  end
endmodule

// *** verification/rqc_classifier_asserts.sv ***
`timescale 1ns/1ps
module rqc_classifier_asserts #(
  parameter int N_CONN = 8
) (
  input wire logic              I_SYS_CLK,
  input wire logic              I_RST,
  input wire logic              I_Q_READY,
  input wire logic              O_Q_VALID,
  input wire logic [1:0]        O_Q_NUM,
  input wire logic [7:0]        O_Q_ID,
  input wire logic              I_RING_BREAK,
  input wire logic              O_FDB_FLUSH,
  input wire logic              O_FLOOD_BOTH,
  input wire logic [1:0]        I_NBR_CHANGE,
  input wire logic              O_LLDP_TX,
  input wire logic              I_CYCLE_START,
  input wire logic              O_LIST_PENDING,
  input wire logic              O_RT_VALID,
  input wire logic [1:0]        O_RT_BUF,
  input wire logic              O_IRQ_DHT,
  input wire logic [N_CONN-1:0] O_DHT_EXPIRED
);
  default clocking @(posedge I_SYS_CLK); endclocking
  default disable iff (I_RST);
  AST_Q_NUM_HOLD: assert property (O_Q_VALID && !I_Q_READY |=> O_Q_VALID && $stable(O_Q_NUM))
    else $error("queue number moved while stalled");
  AST_Q_ID_HOLD: assert property (O_Q_VALID && !I_Q_READY |=> $stable(O_Q_ID))
    else $error("queued frame moved while stalled");
  AST_FLUSH: assert property ($rose(I_RING_BREAK) |-> ##[0:4] O_FDB_FLUSH)
    else $error("no table flush on ring break");
  AST_FLOOD: assert property ($rose(I_RING_BREAK) |-> ##[0:4] O_FLOOD_BOTH)
    else $error("no flooding on ring break");
  AST_LLDP: assert property (I_NBR_CHANGE != 2'h0 |-> ##[0:4] O_LLDP_TX)
    else $error("no discovery frame on neighbour change");
  AST_LIST: assert property ($fell(O_LIST_PENDING) |-> $past(I_CYCLE_START) || $past(I_CYCLE_START, 2))
    else $error("list swapped off a cycle boundary");
  AST_RT_BUF: assert property (O_RT_VALID |-> O_RT_BUF <= rqc_pkg::BUF_IDX_MAX)
    else $error("triple buffer index out of range");
  AST_DHT: assert property ($rose(O_IRQ_DHT) |-> ##[0:2] (O_DHT_EXPIRED != '0))
    else $error("hold interrupt without expired connection");
endmodule
bind rqc_classifier rqc_classifier_asserts #(.N_CONN(N_CONN)) rqc_classifier_asserts_i (.I_SYS_CLK, .I_RST,
  .I_Q_READY, .O_Q_VALID, .O_Q_NUM, .O_Q_ID, .I_RING_BREAK, .O_FDB_FLUSH, .O_FLOOD_BOTH, .I_NBR_CHANGE,
  .O_LLDP_TX, .I_CYCLE_START, .O_LIST_PENDING, .O_RT_VALID, .O_RT_BUF, .O_IRQ_DHT, .O_DHT_EXPIRED);

// *** verification/rqc_host_model.sv ***
`timescale 1ns/1ps
module rqc_host_model (
  input  wire logic       i_clk,
  input  wire logic       i_rst,
  input  wire logic       i_valid,
  input  wire logic [1:0] i_num,
  input  wire logic       i_irq,
  output logic            o_ready = 1'b0,
  output logic            o_ack = 1'b0,
  output logic [15:0]     o_cnt [4]
);
  logic [7:0] lfsr = 8'h5b;
  always @(posedge i_clk) begin
    lfsr <= {lfsr[6:0], lfsr[7] ^ lfsr[5] ^ lfsr[4] ^ lfsr[3]};
    // Stalls about a quarter of cycles
    o_ready <= !i_rst && (lfsr[0] | lfsr[1]);
    o_ack <= i_irq & ~o_ack;
    if (i_rst)
      o_cnt <= '{default: 16'h0};
    else if (i_valid && o_ready)
      o_cnt[i_num] <= o_cnt[i_num] + 16'h1;
  end
endmodule

// *** verification/test_rqc_classifier.sv ***
`timescale 1ns/1ps
module test_rqc_classifier;
  localparam logic [15:0] CTAG = 16'h8001;
  localparam logic [23:0] SUBS = {3'h7, 3'h4, 3'h3, 3'h6, 3'h7, 3'h2, 3'h1, 3'h0};
  logic         clk = 1'b0, rst = 1'b1, fv = 1'b0, vl = 1'b0, bc = 1'b0, we = 1'b0, cmt = 1'b0, cs = 1'b0;
  logic         rb = 1'b0, rr = 1'b0, fr, qv, qr, ack, irq, rv, sv, sm, lt, fb, dr, lpn;
  logic [15:0]  et = 16'h0, tg = 16'h0, cnt [4];
  logic [2:0]   sb = 3'h7, pc = 3'h0, rc;
  logic [1:0]   nb = 2'h0, qn, lp;
  logic [31:0]  tm = 32'h0, ld = 32'h0, bd = 32'h0, lf = 32'h5a01be49, st, tq [$];
  logic [7:0]   ll = 8'h0, fnl = 8'h0, pace = 8'h0, dx;
  logic [127:0] nm = {8{16'h6e31}};
  int           fail_count = 0, total_checks = 0, cyc = 0, ne [7] = '{default: 0}, ng [7] = '{default: 0};
  rqc_classifier #(.TICK_CYC(200)) rqc_classifier_i (.I_SYS_CLK(clk), .I_RST(rst), .I_FRM_VALID(fv),
    .O_FRM_READY(fr), .I_FRM_PORT(nb), .I_FRM_ETYPE(et), .I_FRM_SUB(sb), .I_FRM_TAG(tg), .I_FRM_VLAN(vl),
    .I_FRM_PCP(pc), .I_FRM_BCAST(bc), .I_FRM_ID(tm[7:0]), .I_FRM_NAME_LEN(fnl), .I_FRM_NAME(nm),
    .I_FRM_TIME(tm), .I_LOCAL_NAME_LEN(ll), .I_LOCAL_NAME(nm), .I_LINE_DELAY(ld), .I_BRIDGE_DELAY(bd),
    .I_CYCLE_START(cs), .I_SHD_WE(we), .I_SHD_IDX(sb), .I_SHD_TAG(tg), .I_SHD_EN(we), .I_SHD_RED(vl),
    .I_SHD_COMMIT(cmt), .I_NBR_CHANGE(nb), .I_RING_BREAK(rb), .I_RING_RESTORED(rr), .I_BCAST_LIMIT(8'hff),
    .I_PACE_COUNT(pace), .I_RX_IRQ_ACK(ack), .I_Q_READY(qr), .O_Q_VALID(qv), .O_Q_NUM(qn), .O_Q_PORT(),
    .O_Q_ID(), .O_RT_VALID(rv), .O_RT_RED(), .O_RT_CONN(rc), .O_RT_BUF(), .O_SYNC_VALID(sv), .O_SYNC_MEAS(sm),
    .O_SYNC_PORT(), .O_SYNC_FWD_TIME(st), .O_LLDP_TX(lt), .O_LLDP_PORT(lp), .O_FDB_FLUSH(), .O_FLOOD_BOTH(fb),
    .O_FILTER_DROP(dr), .O_IRQ_BUF(), .O_IRQ_LIST(), .O_IRQ_DHT(), .O_DHT_EXPIRED(dx),
    .O_LIST_PENDING(lpn), .O_IRQ_RX(irq));
  rqc_host_model rqc_host_model_i (.i_clk(clk), .i_rst(rst), .i_valid(qv), .i_num(qn), .i_irq(irq),
    .o_ready(qr), .o_ack(ack), .o_cnt(cnt));
  initial forever #10 clk = ~clk;
  function automatic logic [31:0] nx(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction
  // Destination 0..3 queue, 4 real-time, 5 sync, 6 dropped
  function automatic int dst(input logic [15:0] e, input logic [2:0] s, input logic v, input logic [2:0] p,
                             input logic [7:0] l);
    if (e == rqc_pkg::ETYPE_RT && s == 3'h0) return 4;
    if (e == rqc_pkg::ETYPE_RT && (s == 3'h1 || s == 3'h2)) return 5;
    if (e == rqc_pkg::ETYPE_LLDP || (e == rqc_pkg::ETYPE_RT && s == 3'h6)) return 3;
    if (e == rqc_pkg::ETYPE_RT && s == 3'h4) return l == 8'h4 ? 2 : 6;
    if (e == rqc_pkg::ETYPE_RT) return 2;
    return v && p >= rqc_pkg::PCP_HI_MIN ? 1 : 0;
  endfunction
  task automatic check(input logic [31:0] g, e);
    total_checks++;
    if (g !== e) begin
      fail_count++;
      $display("ERROR %0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic complete_run;
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  task automatic send(input logic [31:0] r);
    logic [2:0] k;
    logic [2:0] s;
    logic [15:0] e;
    k = r[2:0];
    s = (k == 3'h5 && r[3]) ? 3'h5 : SUBS[k*3 +: 3];
    e = k == 3'h3 ? rqc_pkg::ETYPE_LLDP : k == 3'h7 ? 16'h0800 : rqc_pkg::ETYPE_RT;
    et <= e;
    sb <= s;
    tg <= CTAG;
    vl <= k == 3'h7 && r[3];
    pc <= r[6:4];
    bc <= k == 3'h7 && r[7];
    tm <= r;
    fnl <= r[8] ? 8'h4 : 8'h5;
    fv <= 1'b1;
    ne[dst(e, s, k == 3'h7 && r[3], r[6:4], r[8] ? 8'h4 : 8'h5)]++;
    if (s == 3'h1) tq.push_back(r + ld + bd);
    do @(posedge clk); while (fr !== 1'b1);
  endtask
  task automatic pulse_cs;
    cs <= 1'b1;
    @(posedge clk);
    cs <= 1'b0;
    repeat (3) @(posedge clk);
  endtask
  always @(posedge clk) begin
    cyc++;
    if (cyc == 10000) begin
      fail_count++;
      complete_run();
    end
  end
  always @(posedge clk) if (!rst) begin
    ng[4] += rv;
    ng[5] += sv;
    ng[6] += dr;
    if (rv) check(rc, 32'h3);
    if (sv && !sm) check(st, tq.pop_front());
  end
  initial begin
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    ll <= 8'h4;
    ld <= lf;
    bd <= 32'h20;
    pace <= 8'h4;
    we <= 1'b1;
    sb <= 3'h3;
    tg <= CTAG;
    @(posedge clk);
    we <= 1'b0;
    cmt <= 1'b1;
    @(posedge clk);
    cmt <= 1'b0;
    repeat (2) @(posedge clk);
    check(lpn, 1);
    pulse_cs();
    check(lpn, 0);
    repeat (300) begin
      lf = nx(lf);
      send(lf);
    end
    fv <= 1'b0;
    repeat (30) @(posedge clk);
    for (int i = 0; i < 7; i++) check(i < 4 ? 32'(cnt[i]) : ng[i], ne[i]);
    repeat (2) pulse_cs();
    check(dx[3], 0);
    repeat (3) pulse_cs();
    check(dx[3], 1);
    nb <= 2'h1;
    @(posedge clk);
    nb <= 2'h0;
    repeat (8) if (lt !== 1'b1) @(posedge clk);
    check({lt, lp}, {1'b1, rqc_pkg::PORT_B});
    rb <= 1'b1;
    repeat (8) if (fb !== 1'b1) @(posedge clk);
    check(fb, 1);
    rb <= 1'b0;
    rr <= 1'b1;
    @(posedge clk);
    rr <= 1'b0;
    complete_run();
  end
endmodule
